/* File: logic/sfrs_pkg.sv */
`default_nettype none
// ============================================================
// Shared constants and types of the fundamental reset sequencer
// ============================================================
package sfrs_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 125_000_000;   // Core clock rate
  localparam int unsigned STACK_REL_MS = 20;      // Latest stack release
  localparam int unsigned TRAIN_DONE_MS = 100;    // Link training window
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int TMR_W = 24;                      // Reset-clear timer width
  localparam logic [TMR_W-1:0] STACK_REL_CYC =
    TMR_W'(STACK_REL_MS * CYC_PER_MS);
  localparam logic [TMR_W-1:0] TRAIN_DONE_CYC =
    TMR_W'(TRAIN_DONE_MS * CYC_PER_MS);

  // ==========================================================
  // Sizes, reset values and mode table
  // ==========================================================
  localparam int NUM_PORTS = 24;                  // Ports across all stacks
  localparam int ERR_W = 4;                       // Load error code width
  localparam logic [ERR_W-1:0] ERR_NONE = 4'h0;   // Error code reset value
  // Modes that load settings from the serial EEPROM, one bit per mode
  localparam logic [15:0] EEPROM_MODE_MASK = 16'h00ff;

  // ==========================================================
  // Types
  // ==========================================================
  // Boot configuration vector as caught at reset release
  typedef struct packed {
    logic [3:0] switch_operating_select;
    logic reset_halt;
    logic [1:0] slave_bus_addr_inputs;            // Address bits [2:1]
  } sfrs_bcv_t;

  // Mode-dependent defaults for partition and port configuration
  typedef struct packed {
    logic [2:0] partition_count;
    logic [4:0] upstream_port;
  } sfrs_part_cfg_t;

  // Packet classes seen by a port
  typedef enum logic [1:0] {
    TLP_CFG0 = 2'h0,
    TLP_CFG1 = 2'h1,
    TLP_OTHER = 2'h2
  } sfrs_tlp_kind_t;

  // Port answer to a packet
  typedef enum logic [1:0] {
    RSP_NORMAL = 2'h0,
    RSP_RETRY = 2'h1,
    RSP_UNSUPPORTED = 2'h2,
    RSP_DISCARD = 2'h3
  } sfrs_tlp_rsp_t;

endpackage

`default_nettype wire

/* File: logic/sfrs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module sfrs_sequencer
  import sfrs_pkg::*;
#(
  parameter logic [TMR_W-1:0] STACK_REL_CYCLES = STACK_REL_CYC,
  parameter logic [TMR_W-1:0] TRAIN_DONE_CYCLES = TRAIN_DONE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Board reset pin and boot vector
  input wire logic global_reset_n_pin,
  input wire sfrs_bcv_t bcv_pins,
  // Lower-priority reset requests
  input wire logic other_reset_req,
  // Step completion indications
  input wire logic reg_init_done,
  input wire logic pll_serdes_locked,
  input wire logic master_bus_ready,
  input wire logic slave_bus_ready,
  // EEPROM loader
  input wire logic eeprom_load_finished,
  input wire logic eeprom_load_error,
  input wire logic [ERR_W-1:0] eeprom_error_code,
  input wire logic eeprom_wr_valid,
  input wire logic eeprom_wr_phy_state,
  input wire logic eeprom_wr_full_link_retrain,
  input wire logic [4:0] eeprom_wr_port,
  // Slave bus clear of the halt bit
  input wire logic halt_clear_req,
  // Packet classification request
  input wire logic tlp_valid,
  input wire sfrs_tlp_kind_t tlp_kind,
  // Sequencing outputs
  output logic fund_reset_q,
  output logic other_reset_q,
  output sfrs_bcv_t bcv_sampled_q,
  output sfrs_part_cfg_t part_cfg_q,
  output logic reg_init_q,
  output logic register_unlock_q,
  output logic pll_init_q,
  output logic master_bus_en_q,
  output logic slave_bus_en_q,
  output logic [1:0] slave_addr_q,
  output logic stack_release_q,
  output logic train_window_over_q,
  output logic eeprom_load_q,
  output logic eeprom_load_done_q,
  output logic [ERR_W-1:0] two_wire_err_q,
  output logic reset_halt_q,
  output logic quasi_reset_q,
  output logic normal_op_q,
  output logic [NUM_PORTS-1:0] retrain_q,
  // Packet answer
  output logic tlp_rsp_valid_q,
  output sfrs_tlp_rsp_t tlp_rsp_q
);

  // ==========================================================
  // Types and functions
  // ==========================================================
  // One-hot sequencing steps
  typedef enum logic [10:0] {
    ST_RESET = 11'h001,
    ST_SAMPLE = 11'h002,
    ST_REG_INIT = 11'h004,
    ST_UNLOCK = 11'h008,
    ST_PLL = 11'h010,
    ST_MASTER = 11'h020,
    ST_SLAVE = 11'h040,
    ST_EEPROM = 11'h080,
    ST_HALT = 11'h100,
    ST_LOCK = 11'h200,
    ST_NORMAL = 11'h400
  } sfrs_state_t;

  // Whether an operating mode loads the serial EEPROM
  function automatic logic mode_has_eeprom(input logic [3:0] mode);
    mode_has_eeprom = EEPROM_MODE_MASK[mode];
  endfunction

  // Partition and port defaults for an operating mode
  function automatic sfrs_part_cfg_t mode_defaults(input logic [3:0] mode);
    sfrs_part_cfg_t cfg;
    cfg = '0;
    case (mode[1:0])
      2'h0: begin
        cfg.partition_count = 3'h1;
        cfg.upstream_port = 5'h00;
      end
      2'h1: begin
        cfg.partition_count = 3'h2;
        cfg.upstream_port = 5'h00;
      end
      2'h2: begin
        cfg.partition_count = 3'h4;
        cfg.upstream_port = 5'h08;
      end
      default: begin
        cfg.partition_count = 3'h1;
        cfg.upstream_port = 5'h10;
      end
    endcase
    mode_defaults = cfg;
  endfunction

  // ==========================================================
  // Declarations
  // ==========================================================
  logic pin_meta_q;          // First synchroniser stage
  logic pin_sync_q;          // Negated pin, safe to use
  logic in_reset;            // Fundamental reset condition present
  sfrs_state_t state_q;      // Current step
  sfrs_state_t state_d;      // Next step
  logic [TMR_W-1:0] tmr_q;   // Cycles since reset condition cleared
  logic stack_due;           // Stack release deadline reached
  logic quasi_d;             // Ports held in quasi-reset

  // ==========================================================
  // Reset pin synchroniser
  // ==========================================================
  // Assertion clears both stages at once; negation ripples through
  always_ff @(posedge clk or negedge global_reset_n_pin) begin
    if (!global_reset_n_pin) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Same path for cold and warm reset: only srst and the pin are looked at
  assign in_reset = srst || !pin_sync_q;

  // ==========================================================
  // Step sequencing
  // ==========================================================
  // Next step: advance only on the current step's completion
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        state_d = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        state_d = ST_REG_INIT;
      end
      ST_REG_INIT: begin
        if (reg_init_done) begin
          state_d = ST_UNLOCK;
        end
      end
      ST_UNLOCK: begin
        state_d = ST_PLL;
      end
      ST_PLL: begin
        if (pll_serdes_locked) begin
          state_d = ST_MASTER;
        end
      end
      ST_MASTER: begin
        if (master_bus_ready) begin
          state_d = ST_SLAVE;
        end
      end
      ST_SLAVE: begin
        if (slave_bus_ready) begin
          // Skip the load entirely in modes without it
          if (mode_has_eeprom(bcv_sampled_q.switch_operating_select)) begin
            state_d = ST_EEPROM;
          end else begin
            state_d = ST_HALT;
          end
        end
      end
      ST_EEPROM: begin
        // An error aborts the load at once
        if (eeprom_load_error || eeprom_load_finished) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        // Wait here while the halt bit stands
        if (!reset_halt_q) begin
          state_d = ST_LOCK;
        end
      end
      ST_LOCK: begin
        state_d = ST_NORMAL;
      end
      ST_NORMAL: begin
        state_d = ST_NORMAL;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  // Step register; the reset condition wins over everything
  always_ff @(posedge clk) begin
    if (in_reset) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Reset precedence
  // ==========================================================
  // Lower-priority resets pass only outside a fundamental reset
  always_ff @(posedge clk) begin
    if (in_reset) begin
      fund_reset_q <= 1'b1;
      other_reset_q <= 1'b0;
    end else begin
      fund_reset_q <= (state_q == ST_RESET);
      other_reset_q <= other_reset_req && (state_q != ST_RESET);
    end
  end

  // ==========================================================
  // Boot vector capture and mode defaults
  // ==========================================================
  // Caught once on release; pin changes later have no effect
  always_ff @(posedge clk) begin
    if (srst) begin
      bcv_sampled_q <= '0;
    end else if (!in_reset && state_q == ST_RESET) begin
      bcv_sampled_q <= bcv_pins;
    end
  end

  // Defaults follow the sampled mode during register initialisation
  always_ff @(posedge clk) begin
    if (in_reset) begin
      part_cfg_q <= '0;
    end else if (state_q == ST_REG_INIT) begin
      part_cfg_q <= mode_defaults(bcv_sampled_q.switch_operating_select);
    end
  end

  // Register initialisation request while that step runs
  always_ff @(posedge clk) begin
    if (in_reset) begin
      reg_init_q <= 1'b0;
    end else begin
      reg_init_q <= (state_d == ST_REG_INIT);
    end
  end

  // ==========================================================
  // Register unlock
  // ==========================================================
  // Set after initialisation, cleared once the halt has gone
  always_ff @(posedge clk) begin
    if (in_reset) begin
      register_unlock_q <= 1'b0;
    end else if (state_q == ST_UNLOCK) begin
      register_unlock_q <= 1'b1;
    end else if (state_q == ST_LOCK) begin
      register_unlock_q <= 1'b0;
    end
  end

  // ==========================================================
  // Clock and two-wire bus bring-up
  // ==========================================================
  // PLL runs from its step on; buses stay up through halt
  always_ff @(posedge clk) begin
    if (in_reset) begin
      pll_init_q <= 1'b0;
      master_bus_en_q <= 1'b0;
      slave_bus_en_q <= 1'b0;
      slave_addr_q <= 2'h0;
    end else begin
      if (state_q == ST_PLL) begin
        pll_init_q <= 1'b1;
      end
      if (state_q == ST_MASTER) begin
        master_bus_en_q <= 1'b1;
      end
      if (state_q == ST_SLAVE) begin
        slave_bus_en_q <= 1'b1;
        slave_addr_q <= bcv_sampled_q.slave_bus_addr_inputs;
      end
    end
  end

  // ==========================================================
  // Reset-clear timer and stack release
  // ==========================================================
  // Counts from the clearing of the reset and saturates
  always_ff @(posedge clk) begin
    if (in_reset) begin
      tmr_q <= '0;
    end else if (tmr_q != {TMR_W{1'b1}}) begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  assign stack_due = (tmr_q >= STACK_REL_CYCLES - 1'b1);

  // Release on slave bus ready or at the deadline, whichever first
  always_ff @(posedge clk) begin
    if (in_reset) begin
      stack_release_q <= 1'b0;
    end else if (stack_due || (state_q == ST_SLAVE && slave_bus_ready)) begin
      stack_release_q <= 1'b1;
    end
  end

  // Flag set and held once the training window has passed; packet answers ignore it
  always_ff @(posedge clk) begin
    if (in_reset) begin
      train_window_over_q <= 1'b0;
    end else if (tmr_q >= TRAIN_DONE_CYCLES - 1'b1) begin
      train_window_over_q <= 1'b1;
    end
  end

  // ==========================================================
  // EEPROM load
  // ==========================================================
  // Load request for the duration of the load step
  always_ff @(posedge clk) begin
    if (in_reset) begin
      eeprom_load_q <= 1'b0;
    end else begin
      eeprom_load_q <= (state_d == ST_EEPROM);
    end
  end

  // Done flag and recorded error code
  always_ff @(posedge clk) begin
    if (in_reset) begin
      eeprom_load_done_q <= 1'b0;
      two_wire_err_q <= ERR_NONE;
    end else if (state_q == ST_EEPROM) begin
      if (eeprom_load_error) begin
        eeprom_load_done_q <= 1'b1;
        two_wire_err_q <= eeprom_error_code;
      end else if (eeprom_load_finished) begin
        eeprom_load_done_q <= 1'b1;
      end
    end
  end

  // Retrain pulses fire as the loader writes, not at load end
  always_ff @(posedge clk) begin
    if (in_reset) begin
      retrain_q <= '0;
    end else begin
      retrain_q <= '0;
      if (state_q == ST_EEPROM && eeprom_wr_valid && eeprom_wr_phy_state &&
          eeprom_wr_full_link_retrain &&
          eeprom_wr_port < 5'(NUM_PORTS)) begin
        retrain_q[eeprom_wr_port] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Reset halt bit
  // ==========================================================
  // Set by the sampled pin or a load error; a set beats a clear
  always_ff @(posedge clk) begin
    if (in_reset) begin
      reset_halt_q <= 1'b0;
    end else if (state_q == ST_SAMPLE && bcv_sampled_q.reset_halt) begin
      reset_halt_q <= 1'b1;
    end else if (state_q == ST_EEPROM && eeprom_load_error) begin
      reset_halt_q <= 1'b1;
    end else if (halt_clear_req) begin
      reset_halt_q <= 1'b0;
    end
  end

  // ==========================================================
  // Quasi-reset and normal operation
  // ==========================================================
  // Ports wait during the load step and in the halt step
  always_comb begin
    quasi_d = (state_d == ST_EEPROM) || (state_d == ST_HALT);
  end

  always_ff @(posedge clk) begin
    if (in_reset) begin
      quasi_reset_q <= 1'b0;
      normal_op_q <= 1'b0;
    end else begin
      quasi_reset_q <= quasi_d;
      normal_op_q <= (state_d == ST_NORMAL);
    end
  end

  // Packet answer in quasi-reset: retry type 0, refuse type 1, drop the rest; normal otherwise
  always_ff @(posedge clk) begin
    if (in_reset) begin
      tlp_rsp_valid_q <= 1'b0;
      tlp_rsp_q <= RSP_NORMAL;
    end else begin
      tlp_rsp_valid_q <= tlp_valid;
      if (!quasi_reset_q) begin
        tlp_rsp_q <= RSP_NORMAL;
      end else begin
        case (tlp_kind)
          TLP_CFG0: begin
            tlp_rsp_q <= RSP_RETRY;
          end
          TLP_CFG1: begin
            tlp_rsp_q <= RSP_UNSUPPORTED;
          end
          default: begin
            tlp_rsp_q <= RSP_DISCARD;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: tb/sfrs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Checker on the sequencer ports
// ============================================================
module sfrs_checker
  import sfrs_pkg::*;
#(
  parameter logic [TMR_W-1:0] STACK_REL_CYCLES = STACK_REL_CYC,
  parameter logic [TMR_W-1:0] TRAIN_DONE_CYCLES = TRAIN_DONE_CYC
) (
  // Clock, reset and pin
  input wire logic clk,
  input wire logic srst,
  input wire logic global_reset_n_pin,
  // Loader and packets
  input wire logic eeprom_load_error,
  input wire logic [ERR_W-1:0] eeprom_error_code,
  input wire logic eeprom_wr_valid,
  input wire logic eeprom_wr_phy_state,
  input wire logic eeprom_wr_full_link_retrain,
  input wire logic [4:0] eeprom_wr_port,
  input wire logic tlp_valid,
  input wire sfrs_tlp_kind_t tlp_kind,
  // Sequencer outputs
  input wire logic fund_reset_q,
  input wire logic other_reset_q,
  input wire sfrs_bcv_t bcv_sampled_q,
  input wire logic reg_init_q,
  input wire logic register_unlock_q,
  input wire logic pll_init_q,
  input wire logic master_bus_en_q,
  input wire logic stack_release_q,
  input wire logic train_window_over_q,
  input wire logic eeprom_load_q,
  input wire logic eeprom_load_done_q,
  input wire logic [ERR_W-1:0] two_wire_err_q,
  input wire logic reset_halt_q,
  input wire logic quasi_reset_q,
  input wire logic normal_op_q,
  input wire logic [NUM_PORTS-1:0] retrain_q,
  input wire logic tlp_rsp_valid_q,
  input wire sfrs_tlp_rsp_t tlp_rsp_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [TMR_W-1:0] clr_q; // Cycles since pin release
  sfrs_tlp_rsp_t exp_q; // Answer due to last packet
  // Count from pin release, saturating
  always_ff @(posedge clk) begin
    if (srst || !global_reset_n_pin) begin
      clr_q <= '0;
    end else if (~&clr_q) begin
      clr_q <= clr_q + 1'b1;
    end
  end
  // Expected packet answer from the port state
  always_ff @(posedge clk) begin
    if (!quasi_reset_q) begin
      exp_q <= RSP_NORMAL;
    end else begin
      exp_q <= tlp_kind == TLP_CFG0 ? RSP_RETRY :
        tlp_kind == TLP_CFG1 ? RSP_UNSUPPORTED : RSP_DISCARD;
    end
  end
  AST_PIN_HOLD: assert property (!global_reset_n_pin |=> fund_reset_q &&
    !other_reset_q && !normal_op_q && !register_unlock_q)
    else $error("pin low did not hold reset");
  AST_SYNC: assert property ($rose(global_reset_n_pin) |=> fund_reset_q)
    else $error("left reset before sync");
  AST_BCV_HOLD: assert property (!fund_reset_q |=> $stable(bcv_sampled_q))
    else $error("boot vector moved");
  AST_UNLOCK: assert property ($rose(register_unlock_q) |->
    $past(reg_init_q, 2) && !reg_init_q) else $error("unlock before init");
  AST_ORDER: assert property ($rose(master_bus_en_q) |-> pll_init_q)
    else $error("master bus before pll");
  AST_STACK: assert property (clr_q > STACK_REL_CYCLES + 4 |-> stack_release_q)
    else $error("stack release late");
  AST_TRAIN: assert property (clr_q > TRAIN_DONE_CYCLES + 4 |->
    train_window_over_q) else $error("training window late");
  AST_MODE: assert property ($rose(eeprom_load_q) |->
    EEPROM_MODE_MASK[bcv_sampled_q.switch_operating_select])
    else $error("load in wrong mode");
  AST_RETRAIN: assert property (eeprom_wr_valid && eeprom_wr_phy_state &&
    eeprom_wr_full_link_retrain && eeprom_load_q && eeprom_wr_port < 5'h18
    |=> retrain_q[$past(eeprom_wr_port)]) else $error("no retrain");
  AST_LOAD_ERR: assert property (eeprom_load_q && eeprom_load_error |=>
    reset_halt_q && two_wire_err_q == $past(eeprom_error_code))
    else $error("load error not kept");
  AST_TLP: assert property (tlp_valid ##1 $stable(quasi_reset_q) |->
    tlp_rsp_valid_q && tlp_rsp_q == exp_q) else $error("bad packet answer");
  COV_LOAD: cover property ($rose(eeprom_load_done_q));
  COV_HALT: cover property ($fell(reset_halt_q));
  COV_RUN: cover property ($rose(normal_op_q));
endmodule
bind sfrs_sequencer sfrs_checker #(
  .STACK_REL_CYCLES(STACK_REL_CYCLES),
  .TRAIN_DONE_CYCLES(TRAIN_DONE_CYCLES)
) i_sfrs_checker (.*);
`default_nettype wire

/* File: tb/sfrs_partner_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bring-up units, EEPROM loader and slave bus master
// ============================================================
module sfrs_partner_model
  import sfrs_pkg::*;
(
  // Clock, reset and scenario controls
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic load_err,
  input wire logic halt_clr_en,
  // Sequencer outputs watched
  input wire logic reg_init_q,
  input wire logic pll_init_q,
  input wire logic master_bus_en_q,
  input wire logic slave_bus_en_q,
  input wire logic eeprom_load_q,
  input wire logic reset_halt_q,
  // Answers to the sequencer
  output logic reg_init_done,
  output logic pll_serdes_locked,
  output logic master_bus_ready,
  output logic slave_bus_ready,
  output logic eeprom_load_finished,
  output logic eeprom_load_error,
  output logic [ERR_W-1:0] eeprom_error_code,
  output logic eeprom_wr_valid,
  output logic eeprom_wr_phy_state,
  output logic eeprom_wr_full_link_retrain,
  output logic [4:0] eeprom_wr_port,
  output logic halt_clear_req
);
  localparam logic [ERR_W-1:0] ERR_CODE = 4'h9; // Load error detail
  logic [3:0] en, en_q; // Step enables and last copy
  logic [7:0] w_q, lc_q; // Step wait and load progress
  logic go;
  assign en = {slave_bus_en_q, master_bus_en_q, pll_init_q, reg_init_q};
  // Wait restarts whenever a new step is enabled
  always_ff @(posedge clk) begin
    en_q <= en;
    if (srst || en != en_q) begin
      w_q <= 8'h00;
    end else if (w_q != 8'hff) begin
      w_q <= w_q + 8'h01;
    end
  end
  assign go = en == en_q && w_q >= (slow ? 8'h14 : 8'h01);
  assign {slave_bus_ready, master_bus_ready, pll_serdes_locked,
    reg_init_done} = en & {4{go}};
  // Load progress, idle outside a load
  always_ff @(posedge clk) begin
    if (srst || !eeprom_load_q) begin
      lc_q <= 8'h00;
    end else if (lc_q != 8'hff) begin
      lc_q <= lc_q + 8'h01;
    end
  end
  // One retrain write to port 5 early in the load
  assign eeprom_wr_valid = lc_q == 8'h04;
  assign eeprom_wr_phy_state = eeprom_wr_valid;
  assign eeprom_wr_full_link_retrain = eeprom_wr_valid;
  assign eeprom_wr_port = eeprom_wr_valid ? 5'h05 : ~lc_q[4:0];
  // Load ends far inside its time budget
  assign eeprom_load_finished = lc_q == 8'h18 && !load_err;
  assign eeprom_load_error = lc_q == 8'h18 && load_err;
  assign eeprom_error_code = eeprom_load_error ? ERR_CODE : lc_q[3:0];
  // Master clears the halt once it has set up the device
  assign halt_clear_req = halt_clr_en && reset_halt_q &&
    !eeprom_load_q && w_q > 8'h1e;
endmodule
`default_nettype wire

/* File: tb/sfrs_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench for the fundamental reset sequencer
// ============================================================
module sfrs_sequencer_tb;
  import sfrs_pkg::*;
  logic clk, srst, global_reset_n_pin, other_reset_req, tlp_valid;
  sfrs_bcv_t bcv_pins, bcv_sampled_q;
  sfrs_tlp_kind_t tlp_kind;
  logic reg_init_done, pll_serdes_locked, master_bus_ready;
  logic slave_bus_ready, eeprom_load_finished, eeprom_load_error;
  logic eeprom_wr_valid, eeprom_wr_phy_state, eeprom_wr_full_link_retrain;
  logic halt_clear_req, fund_reset_q, other_reset_q, reg_init_q;
  logic register_unlock_q, pll_init_q, master_bus_en_q, slave_bus_en_q;
  logic stack_release_q, train_window_over_q, eeprom_load_q;
  logic eeprom_load_done_q, reset_halt_q, quasi_reset_q, normal_op_q;
  logic tlp_rsp_valid_q, slow, load_err, halt_clr_en, rt_seen, rt_in_load;
  logic [ERR_W-1:0] eeprom_error_code, two_wire_err_q;
  logic [4:0] eeprom_wr_port;
  logic [1:0] slave_addr_q;
  sfrs_part_cfg_t part_cfg_q;
  logic [NUM_PORTS-1:0] retrain_q;
  sfrs_tlp_rsp_t tlp_rsp_q;
  int fails, checked, n, c0, cyc;
  sfrs_tlp_kind_t kk[3] = '{TLP_CFG0, TLP_CFG1, TLP_OTHER};
  sfrs_tlp_rsp_t rr[3] = '{RSP_RETRY, RSP_UNSUPPORTED, RSP_DISCARD};
  sfrs_sequencer #(
    .STACK_REL_CYCLES(24'h000028),
    .TRAIN_DONE_CYCLES(24'h000050)
  ) i_sfrs_sequencer (.*);
  sfrs_partner_model i_sfrs_partner_model (.*);
  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Cycle limit and retrain monitor
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (retrain_q[5] === 1'b1) begin
      rt_seen <= 1'b1;
      rt_in_load <= eeprom_load_q;
    end
    if (cyc == 4000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Pulse the board pin with a boot vector and lower reset pending
  task automatic boot(input sfrs_bcv_t v, input logic sl, input logic le);
    @(posedge clk);
    global_reset_n_pin <= 1'b0;
    bcv_pins <= v;
    other_reset_req <= 1'b1;
    slow <= sl;
    load_err <= le;
    halt_clr_en <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(other_reset_q, 0);
    chk(fund_reset_q, 1);
    @(posedge clk);
    global_reset_n_pin <= 1'b1;
    other_reset_req <= 1'b0;
    @(posedge clk);
    #1 chk(fund_reset_q, 1);
  endtask
  // Wait for run, halted quasi-reset or load, in mask order
  task automatic wait_st(input logic [2:0] m);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (({normal_op_q, reset_halt_q & quasi_reset_q & ~eeprom_load_q,
      eeprom_load_q} & m) == 3'h0 && n < 400);
    chk(n < 400, 1);
  endtask
  // Each packet class, answer by port state
  task automatic tlps(input logic q);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      tlp_valid <= 1'b1;
      tlp_kind <= kk[i];
      @(posedge clk);
      tlp_valid <= 1'b0;
      #1 chk(tlp_rsp_q, q ? rr[i] : RSP_NORMAL);
      chk(tlp_rsp_valid_q, 1);
    end
  endtask
  initial begin
    {srst, global_reset_n_pin, other_reset_req, tlp_valid} = 4'h8;
    {slow, load_err, halt_clr_en, rt_seen, rt_in_load} = 5'h00;
    bcv_pins = '0;
    tlp_kind = TLP_CFG0;
    {fails, checked, cyc} = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    // Cold start, no load, no halt
    boot(sfrs_bcv_t'(7'h42), 1'b0, 1'b0);
    wait_st(3'h4);
    c0 = n;
    chk(bcv_sampled_q, 7'h42);
    chk(slave_addr_q, 2'h2);
    chk(part_cfg_q, 8'h20);
    chk({eeprom_load_done_q, register_unlock_q, stack_release_q}, 1);
    @(posedge clk);
    bcv_pins <= sfrs_bcv_t'(7'h3d);
    repeat (3) @(posedge clk);
    #1 chk(bcv_sampled_q, 7'h42);
    // Warm start runs the same course
    boot(sfrs_bcv_t'(7'h42), 1'b0, 1'b0);
    wait_st(3'h4);
    chk(n, c0);
    tlps(1'b0);
    // Load with a retrain write
    boot(sfrs_bcv_t'(7'h19), 1'b0, 1'b0);
    wait_st(3'h1);
    tlps(1'b1);
    chk(part_cfg_q, 8'h30);
    wait_st(3'h4);
    chk({eeprom_load_done_q, reset_halt_q, rt_seen, rt_in_load}, 4'hb);
    // Load that fails halts the device
    boot(sfrs_bcv_t'(7'h19), 1'b0, 1'b1);
    wait_st(3'h2);
    chk(two_wire_err_q, 4'h9);
    chk({normal_op_q, register_unlock_q}, 1);
    tlps(1'b1);
    @(posedge clk);
    halt_clr_en <= 1'b1;
    wait_st(3'h4);
    chk({register_unlock_q, reset_halt_q}, 0);
    // Slow bring-up with halt pin: stacks freed by deadline
    boot(sfrs_bcv_t'(7'h47), 1'b1, 1'b0);
    repeat (46) @(posedge clk);
    #1 chk({stack_release_q, slave_bus_en_q}, 2);
    wait_st(3'h2);
    chk({reset_halt_q, normal_op_q}, 2);
    chk({master_bus_en_q, slave_bus_en_q, train_window_over_q}, 7);
    @(posedge clk);
    halt_clr_en <= 1'b1;
    wait_st(3'h4);
    chk(register_unlock_q, 0);
    finish_test();
  end
endmodule
`default_nettype wire
